// File: dpd_device.sv
`include "dpd_map.svh"

// Contract
// - Host sends B9h with select low.
// - Exactly eight bits, else request discarded.
// - Select rise starts power-down entry.
// - Down: only ABh, 66h+99h, FFh wake.
// - Down: every other code is ignored.
// - Reset always lands in normal standby; the code ignores reset frames while entering or releasing.
// - ABh frame requests release.
// - Release waits recovery before accepting commands.
// - Host keeps select high during recovery.
// - Host waits 200 us before select.
// - Host waits 1 ms before writes.
// - Entry completes within 3 us.
// - Release completes within 1.5 ms.
module dpd_device #(
    parameter int RELEASE_CYCLES = `DPD_RELEASE_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Serial link
    dpd_if.dev link,
    // Status
    output logic poweredDown,
    output logic standby,
    // Accepted commands in normal operation; reset requests also from power-down
    output logic cmdValid,
    output logic [7:0] cmdCode,
    output logic resetReq,
    // Response byte for the second byte of a frame
    input wire logic respEn,
    input wire logic [7:0] respData
);

    localparam logic [13:0] ENTRY_LAST = 14'(`DPD_ENTRY_CYCLES - `DPD_PIN_LAG);
    localparam logic [13:0] RELEASE_LAST = 14'(RELEASE_CYCLES - `DPD_PIN_LAG);

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [2:0] pinRaw;
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] sync3;
    logic [2:0] pin_reg;
    logic [2:0] pinPrev_reg;

    assign pinRaw = {link.csN, link.sclk, link.mosi};

    genvar i;
    generate
        for (i = 0; i < 3; i++)
        begin : gSync
            localparam logic [2:0] IDLE = `DPD_PIN_IDLE;
            always_ff @(posedge clk or posedge rst)
            begin
                if (rst)
                begin
                    sync1[i] <= IDLE[i];
                    sync2[i] <= IDLE[i];
                    sync3[i] <= IDLE[i];
                    pin_reg[i] <= IDLE[i];
                    pinPrev_reg[i] <= IDLE[i];
                end
                else
                begin
                    sync1[i] <= pinRaw[i];
                    sync2[i] <= sync1[i];
                    sync3[i] <= sync2[i];
                    if (sync2[i] == sync3[i])
                    begin
                        pin_reg[i] <= sync3[i];
                    end
                    pinPrev_reg[i] <= pin_reg[i];
                end
            end
        end
    endgenerate

    logic csLow;
    logic csFall;
    logic csRise;
    logic sclkRise;
    logic sclkFall;

    assign csLow = ~pin_reg[2];
    assign csFall = pinPrev_reg[2] & ~pin_reg[2];
    assign csRise = ~pinPrev_reg[2] & pin_reg[2];
    assign sclkRise = csLow & ~pinPrev_reg[1] & pin_reg[1];
    assign sclkFall = csLow & pinPrev_reg[1] & ~pin_reg[1];

    // ****************************************************************
    // Command byte capture
    // ****************************************************************
    logic [2:0] bitCnt_reg;
    logic [1:0] byteCnt_reg;
    logic [7:0] shift_reg;
    logic [7:0] firstByte_reg;
    logic [7:0] shiftNext;
    logic byteDone;
    logic exactFrame;

    assign shiftNext = {shift_reg[6:0], pin_reg[0]};
    assign byteDone = sclkRise && (bitCnt_reg == `DPD_LAST_BIT);
    assign exactFrame = csRise && (byteCnt_reg == 2'h1) && (bitCnt_reg == 3'h0);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            bitCnt_reg <= 3'h0;
            byteCnt_reg <= 2'h0;
            shift_reg <= 8'h00;
            firstByte_reg <= 8'h00;
        end
        else if (csFall)
        begin
            bitCnt_reg <= 3'h0;
            byteCnt_reg <= 2'h0;
        end
        else if (sclkRise)
        begin
            shift_reg <= shiftNext;
            bitCnt_reg <= bitCnt_reg + 3'h1;
            if (byteDone && byteCnt_reg != 2'h2)
            begin
                byteCnt_reg <= byteCnt_reg + 2'h1;
            end
            if (byteDone && byteCnt_reg == 2'h0)
            begin
                firstByte_reg <= shiftNext;
            end
        end
    end

    logic isEnter;
    logic isRelease;
    logic isRstEnable;
    logic isReset;
    logic armed_reg;

    assign isEnter = exactFrame && (firstByte_reg == `DPD_CMD_ENTER);
    assign isRelease = exactFrame && (firstByte_reg == `DPD_CMD_RELEASE);
    assign isRstEnable = exactFrame && (firstByte_reg == `DPD_CMD_RST_ENABLE);
    assign isReset = exactFrame && ((firstByte_reg == `DPD_CMD_RST_ALT) ||
                     (armed_reg && firstByte_reg == `DPD_CMD_RST));

    // ****************************************************************
    // Power state
    // ****************************************************************
    dpd_pkg::dpd_dev_state_t state_reg;
    logic [13:0] waitCnt_reg;
    logic resetReq_reg;

    // reset leaves the device in normal standby
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= dpd_pkg::DEV_NORMAL;
            waitCnt_reg <= 14'h0000;
            resetReq_reg <= 1'b0;
            armed_reg <= 1'b0;
        end
        else
        begin
            resetReq_reg <= 1'b0;
            waitCnt_reg <= waitCnt_reg + 14'h0001;
            if (csRise)
            begin
                armed_reg <= isRstEnable && (state_reg == dpd_pkg::DEV_NORMAL ||
                             state_reg == dpd_pkg::DEV_DOWN);
            end
            case (state_reg)
                dpd_pkg::DEV_NORMAL:
                begin
                    if (isEnter)
                    begin
                        state_reg <= dpd_pkg::DEV_ENTERING;
                        waitCnt_reg <= 14'h0000;
                    end
                    else if (isReset)
                    begin
                        resetReq_reg <= 1'b1;
                    end
                end
                dpd_pkg::DEV_ENTERING:
                begin
                    if (waitCnt_reg >= ENTRY_LAST)
                    begin
                        state_reg <= dpd_pkg::DEV_DOWN;
                    end
                end
                dpd_pkg::DEV_DOWN:
                begin
                    if (isRelease)
                    begin
                        state_reg <= dpd_pkg::DEV_RELEASING;
                        waitCnt_reg <= 14'h0000;
                    end
                    else if (isReset)
                    begin
                        state_reg <= dpd_pkg::DEV_NORMAL;
                        resetReq_reg <= 1'b1;
                    end
                end
                dpd_pkg::DEV_RELEASING:
                begin
                    if (waitCnt_reg >= RELEASE_LAST)
                    begin
                        state_reg <= dpd_pkg::DEV_NORMAL;
                    end
                end
                default:
                begin
                    state_reg <= dpd_pkg::DEV_NORMAL;
                end
            endcase
        end
    end

    // ****************************************************************
    // Command forwarding and status
    // ****************************************************************
    logic cmdValid_reg;
    logic [7:0] cmdCode_reg;
    logic poweredDown_reg;
    logic standby_reg;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cmdValid_reg <= 1'b0;
            cmdCode_reg <= 8'h00;
            poweredDown_reg <= 1'b0;
            standby_reg <= 1'b0;
        end
        else
        begin
            cmdValid_reg <= byteDone && (byteCnt_reg == 2'h0) &&
                            (state_reg == dpd_pkg::DEV_NORMAL);
            if (byteDone && byteCnt_reg == 2'h0)
            begin
                cmdCode_reg <= shiftNext;
            end
            poweredDown_reg <= (state_reg == dpd_pkg::DEV_DOWN);
            standby_reg <= (state_reg == dpd_pkg::DEV_NORMAL);
        end
    end

    // ****************************************************************
    // Response shifter
    // ****************************************************************
    logic respArm_reg;
    logic misoOe_reg;
    logic miso_reg;
    logic [7:0] respShift_reg;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            respArm_reg <= 1'b0;
            misoOe_reg <= 1'b0;
            miso_reg <= 1'b0;
            respShift_reg <= 8'h00;
        end
        // output released while down or idle
        else if (!csLow || state_reg != dpd_pkg::DEV_NORMAL)
        begin
            respArm_reg <= 1'b0;
            misoOe_reg <= 1'b0;
        end
        else if (byteDone && byteCnt_reg == 2'h0)
        begin
            respArm_reg <= respEn;
        end
        else if (sclkFall && respArm_reg)
        begin
            respArm_reg <= 1'b0;
            misoOe_reg <= 1'b1;
            miso_reg <= respData[7];
            respShift_reg <= {respData[6:0], 1'b0};
        end
        else if (sclkFall && misoOe_reg)
        begin
            miso_reg <= respShift_reg[7];
            respShift_reg <= {respShift_reg[6:0], 1'b0};
        end
    end

    assign link.miso = miso_reg;
    assign link.misoOe = misoOe_reg;
    assign poweredDown = poweredDown_reg;
    assign standby = standby_reg;
    assign cmdValid = cmdValid_reg;
    assign cmdCode = cmdCode_reg;
    assign resetReq = resetReq_reg;

endmodule : dpd_device

// File: dpd_host.sv
`include "dpd_map.svh"

module dpd_host #(
    parameter int SELECT_DELAY_CYCLES = `DPD_SELECT_DELAY_CYCLES,
    parameter int WRITE_DELAY_CYCLES = `DPD_WRITE_DELAY_CYCLES,
    parameter int RELEASE_CYCLES = `DPD_RELEASE_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Serial link
    dpd_if.host link,
    // Command request
    input wire logic cmdStart,
    input wire logic [7:0] cmdCode,
    input wire logic cmdRead,
    input wire logic cmdWrite,
    // Status and answer
    output logic cmdReady,
    output logic writeAllowed,
    output logic cmdDone,
    output logic [7:0] rxData,
    output logic linkAsleep
);

    localparam logic [13:0] SELECT_LAST = 14'(SELECT_DELAY_CYCLES - 1);
    localparam logic [13:0] WRITE_LAST = 14'(WRITE_DELAY_CYCLES - 1);
    localparam logic [13:0] RELEASE_WAIT = 14'(RELEASE_CYCLES);
    localparam logic [13:0] ENTRY_WAIT = 14'(`DPD_ENTRY_CYCLES);

    dpd_pkg::dpd_host_state_t state_reg;
    logic [13:0] waitCnt_reg;
    logic [13:0] waitTarget_reg;
    logic [13:0] upCnt_reg;
    logic writeOk_reg;
    logic [3:0] div_reg;
    logic [2:0] bit_reg;
    logic second_reg;
    logic twoBytes_reg;
    logic [7:0] tx_reg;
    logic [7:0] code_reg;
    logic [7:0] rx_reg;
    logic csN_reg;
    logic sclk_reg;
    logic mosi_reg;
    logic done_reg;
    logic asleep_reg;
    logic accept;

    assign accept = (state_reg == dpd_pkg::HST_IDLE) && cmdStart && (!cmdWrite || writeOk_reg);

    // ****************************************************************
    // Write delay after power-up
    // ****************************************************************
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            upCnt_reg <= 14'h0000;
            writeOk_reg <= 1'b0;
        end
        else if (!writeOk_reg)
        begin
            upCnt_reg <= upCnt_reg + 14'h0001;
            writeOk_reg <= (upCnt_reg >= WRITE_LAST);
        end
    end

    // ****************************************************************
    // Frame sequencer
    // ****************************************************************
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= dpd_pkg::HST_POWERUP;
            waitCnt_reg <= 14'h0000;
            waitTarget_reg <= 14'h0000;
            div_reg <= 4'h0;
            bit_reg <= 3'h0;
            second_reg <= 1'b0;
            twoBytes_reg <= 1'b0;
            tx_reg <= 8'h00;
            code_reg <= 8'h00;
            rx_reg <= 8'h00;
            csN_reg <= 1'b1;
            sclk_reg <= 1'b0;
            mosi_reg <= 1'b0;
            done_reg <= 1'b0;
            asleep_reg <= 1'b0;
        end
        else
        begin
            done_reg <= 1'b0;
            waitCnt_reg <= waitCnt_reg + 14'h0001;
            div_reg <= div_reg + 4'h1;
            case (state_reg)
                dpd_pkg::HST_POWERUP:
                begin
                    if (waitCnt_reg >= SELECT_LAST)
                    begin
                        state_reg <= dpd_pkg::HST_IDLE;
                    end
                end
                dpd_pkg::HST_IDLE:
                begin
                    if (accept)
                    begin
                        state_reg <= dpd_pkg::HST_SHIFT;
                        csN_reg <= 1'b0;
                        mosi_reg <= cmdCode[7];
                        tx_reg <= {cmdCode[6:0], 1'b0};
                        code_reg <= cmdCode;
                        twoBytes_reg <= cmdRead;
                        second_reg <= 1'b0;
                        bit_reg <= 3'h0;
                        div_reg <= 4'h0;
                    end
                end
                dpd_pkg::HST_SHIFT:
                begin
                    if (div_reg == `DPD_SCLK_HALF - 4'h1)
                    begin
                        div_reg <= 4'h0;
                        sclk_reg <= ~sclk_reg;
                        if (!sclk_reg)
                        begin
                            rx_reg <= {rx_reg[6:0], link.misoLine};
                        end
                        // select rises right after eighth bit of the last byte
                        else if (bit_reg == `DPD_LAST_BIT && (second_reg || !twoBytes_reg))
                        begin
                            state_reg <= dpd_pkg::HST_GAP;
                            waitCnt_reg <= 14'h0000;
                        end
                        else
                        begin
                            bit_reg <= bit_reg + 3'h1;
                            second_reg <= second_reg | (bit_reg == `DPD_LAST_BIT);
                            mosi_reg <= tx_reg[7];
                            tx_reg <= {tx_reg[6:0], 1'b0};
                        end
                    end
                end
                dpd_pkg::HST_GAP:
                begin
                    if (waitCnt_reg == 14'h0000)
                    begin
                        csN_reg <= 1'b1;
                    end
                    if (waitCnt_reg == 14'(`DPD_CS_GAP))
                    begin
                        state_reg <= dpd_pkg::HST_WAIT;
                        waitCnt_reg <= 14'h0000;
                        waitTarget_reg <= 14'h0000;
                        if (!twoBytes_reg && code_reg == `DPD_CMD_ENTER)
                        begin
                            waitTarget_reg <= ENTRY_WAIT;
                            asleep_reg <= 1'b1;
                        end
                        else if (!twoBytes_reg && code_reg == `DPD_CMD_RELEASE)
                        begin
                            waitTarget_reg <= RELEASE_WAIT;
                            asleep_reg <= 1'b0;
                        end
                        else if (!twoBytes_reg && (code_reg == `DPD_CMD_RST ||
                                 code_reg == `DPD_CMD_RST_ALT))
                        begin
                            asleep_reg <= 1'b0;
                        end
                    end
                end
                dpd_pkg::HST_WAIT:
                begin
                    if (waitCnt_reg >= waitTarget_reg)
                    begin
                        state_reg <= dpd_pkg::HST_IDLE;
                        done_reg <= 1'b1;
                    end
                end
                default:
                begin
                    state_reg <= dpd_pkg::HST_IDLE;
                    csN_reg <= 1'b1;
                end
            endcase
        end
    end

    logic ready_reg;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ready_reg <= 1'b0;
        end
        else
        begin
            ready_reg <= (state_reg == dpd_pkg::HST_IDLE) && !accept;
        end
    end

    assign link.csN = csN_reg;
    assign link.sclk = sclk_reg;
    assign link.mosi = mosi_reg;
    assign cmdReady = ready_reg;
    assign writeAllowed = writeOk_reg;
    assign cmdDone = done_reg;
    assign rxData = rx_reg;
    assign linkAsleep = asleep_reg;

endmodule : dpd_host

// File: dpd_if.sv
interface dpd_if;
    logic csN;
    logic sclk;
    logic mosi;
    logic miso;
    logic misoOe;
    logic misoLine;

    // Undriven data line is pulled high.
    assign misoLine = misoOe ? miso : 1'b1;

    modport dev (
        input csN,
        input sclk,
        input mosi,
        output miso,
        output misoOe
    );

    modport host (
        output csN,
        output sclk,
        output mosi,
        input misoLine
    );
endinterface : dpd_if

// File: dpd_link_chk.sv
module dpd_link_chk #(
    parameter int SELECT_DELAY_CYCLES = 20,
    parameter int RELEASE_CYCLES = 50
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Link
    input wire logic csN,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic misoOe,
    // Device status
    input wire logic poweredDown,
    input wire logic standby
);
    timeunit 1ns;
    timeprecision 1ns;

    localparam int RelMax = RELEASE_CYCLES - 5;
    logic sclkReg;
    logic [4:0] bitReg;
    int upReg;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // ****************************************************************
    // Helper counters
    // ****************************************************************
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            sclkReg <= 1'b0;
        else
            sclkReg <= sclk;
    end

    // Counts serial clock rises within one select frame.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            bitReg <= 5'h00;
        else if (csN)
            bitReg <= 5'h00;
        else if (sclk && !sclkReg)
            bitReg <= bitReg + 5'h01;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            upReg <= 0;
        else if (upReg < SELECT_DELAY_CYCLES)
            upReg <= upReg + 1;
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    // starts in standby
    start_normal_a: assert property ($fell(rst) |-> !poweredDown ##[1:2] standby)
        else $error("not in standby after reset");
    out_quiet_a: assert property (!standby |-> !misoOe)
        else $error("data driven outside normal state");
    entry_time_a: assert property ($fell(standby) && !poweredDown |-> ##[1:25] poweredDown)
        else $error("power-down entry too slow");
    release_time_a: assert property ($fell(poweredDown) && !standby |-> ##[1:RelMax] standby)
        else $error("release recovery too slow");
    recovery_select_a: assert property ($fell(poweredDown) && !standby |-> csN until standby)
        else $error("select low during recovery");
    wake_deselect_a: assert property ($fell(poweredDown) |-> csN && $past(csN, 2))
        else $error("wake without frame end");
    entry_deselect_a: assert property ($rose(poweredDown) |-> csN && $past(csN, 30))
        else $error("entry without frame end");
    frame_bits_a: assert property ($rose(csN) |-> bitReg == 5'h08 || bitReg == 5'h10)
        else $error("frame not whole bytes");
    clock_idle_a: assert property (csN |-> !sclk)
        else $error("serial clock runs while deselected");
    data_stable_a: assert property (!csN && sclk |-> $stable(mosi))
        else $error("data moved while clock high");
    select_delay_a: assert property ($fell(csN) |-> upReg >= SELECT_DELAY_CYCLES)
        else $error("select too soon after reset");
endmodule : dpd_link_chk

// File: dpd_map.svh
`ifndef DPD_MAP_SVH
`define DPD_MAP_SVH

// ****************************************************************
// Command codes and frame shape
// ****************************************************************
`define DPD_CMD_ENTER 8'hb9
`define DPD_CMD_RELEASE 8'hab
`define DPD_CMD_RST_ENABLE 8'h66
`define DPD_CMD_RST 8'h99
`define DPD_CMD_RST_ALT 8'hff
`define DPD_LAST_BIT 3'h7
`define DPD_PIN_IDLE 3'h4

// ****************************************************************
// Timing
// ****************************************************************
`define DPD_CLK_PERIOD_NS 100
`define DPD_ENTRY_TIME_NS 3000
`define DPD_ENTRY_CYCLES ((`DPD_ENTRY_TIME_NS) / (`DPD_CLK_PERIOD_NS))
`define DPD_RELEASE_TIME_NS 1500000
`define DPD_RELEASE_CYCLES ((`DPD_RELEASE_TIME_NS) / (`DPD_CLK_PERIOD_NS))
`define DPD_SELECT_DELAY_US 200
`define DPD_SELECT_DELAY_CYCLES ((`DPD_SELECT_DELAY_US * 1000 + `DPD_CLK_PERIOD_NS - 1) / (`DPD_CLK_PERIOD_NS))
`define DPD_WRITE_DELAY_MS 1
`define DPD_WRITE_DELAY_CYCLES ((`DPD_WRITE_DELAY_MS * 1000000 + `DPD_CLK_PERIOD_NS - 1) / (`DPD_CLK_PERIOD_NS))
`define DPD_SCLK_HALF 4'h8
`define DPD_CS_GAP 4'h8
// Select edge to state change lag, with margin.
`define DPD_PIN_LAG 7

`endif

// File: dpd_pkg.sv
package dpd_pkg;

    typedef enum logic [1:0] {
        DEV_NORMAL = 2'b00,
        DEV_ENTERING = 2'b01,
        DEV_DOWN = 2'b11,
        DEV_RELEASING = 2'b10
    } dpd_dev_state_t;

    typedef enum logic [2:0] {
        HST_POWERUP = 3'b000,
        HST_IDLE = 3'b001,
        HST_SHIFT = 3'b011,
        HST_GAP = 3'b010,
        HST_WAIT = 3'b110
    } dpd_host_state_t;

endpackage : dpd_pkg

// File: spi_deep_power_down_control_bench.sv
module spi_deep_power_down_control_bench;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int Rel = 50;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cmdStart = 1'b0;
    logic [7:0] cmdCode = 8'h00;
    logic cmdRead = 1'b0;
    logic cmdWrite = 1'b0;
    logic respEn = 1'b1;
    logic [7:0] respData = 8'h00;
    logic cmdReady, writeAllowed, cmdDone, linkAsleep, poweredDown, standby;
    logic cmdValid, resetReq, down2;
    logic [7:0] rxData, devCode, code;
    int errorCnt = 0;
    int cmpCount = 0;
    int validCnt = 0;
    int resetCnt = 0;
    int v0;

    dpd_if link ();
    dpd_if link2 ();

    dpd_host #(.SELECT_DELAY_CYCLES(20), .WRITE_DELAY_CYCLES(40), .RELEASE_CYCLES(Rel))
        dpd_host_inst (.clk(clk), .rst(rst), .link(link), .cmdStart(cmdStart),
        .cmdCode(cmdCode), .cmdRead(cmdRead), .cmdWrite(cmdWrite), .cmdReady(cmdReady),
        .writeAllowed(writeAllowed), .cmdDone(cmdDone), .rxData(rxData),
        .linkAsleep(linkAsleep));
    dpd_device #(.RELEASE_CYCLES(Rel)) dpd_device_inst (.clk(clk), .rst(rst), .link(link),
        .poweredDown(poweredDown), .standby(standby), .cmdValid(cmdValid),
        .cmdCode(devCode), .resetReq(resetReq), .respEn(respEn), .respData(respData));
    // Second device is driven by the bench to break the framing on purpose.
    dpd_device #(.RELEASE_CYCLES(Rel)) dpd_device_inst2 (.clk(clk), .rst(rst),
        .link(link2), .poweredDown(down2), .standby(), .cmdValid(), .cmdCode(),
        .resetReq(), .respEn(respEn), .respData(respData));
    dpd_link_chk #(.SELECT_DELAY_CYCLES(20), .RELEASE_CYCLES(Rel)) dpd_link_chk_inst (
        .clk(clk), .rst(rst), .csN(link.csN), .sclk(link.sclk), .mosi(link.mosi),
        .misoOe(link.misoOe), .poweredDown(poweredDown), .standby(standby));

    always #50 clk = ~clk;

    always @(negedge clk)
    begin
        validCnt += (cmdValid === 1'b1);
        resetCnt += (resetReq === 1'b1);
    end

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [7:0] expRx(input logic asleep, input logic [7:0] resp);
        return asleep ? 8'hff : resp;
    endfunction : expRx

    function automatic logic [7:0] plain(input logic [7:0] c);
        return (c inside {8'hb9, 8'hab, 8'h66, 8'h99, 8'hff}) ? 8'h05 : c;
    endfunction : plain

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmpCount++;
        if (seen !== exp)
        begin
            errorCnt++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wrap_up();
        $display("compares %0d, mismatches %0d", cmpCount, errorCnt);
        if (errorCnt == 0 && cmpCount > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : wrap_up

    task automatic send(input logic [7:0] c, input logic rd, input logic wr);
        int n = 0;
        while (cmdReady !== 1'b1 && n++ < 3000)
            @(negedge clk);
        cmdCode = c;
        cmdRead = rd;
        cmdWrite = wr;
        respData = 8'($urandom);
        cmdStart = 1'b1;
        @(negedge clk);
        cmdStart = 1'b0;
        n = 0;
        while (cmdDone !== 1'b1 && n++ < 3000)
            @(negedge clk);
        if (n > 3000)
            errorCnt++;
    endtask : send

    task automatic settle(input logic down);
        int n = 0;
        while ((poweredDown !== down || standby !== !down) && n++ < 100)
            @(negedge clk);
        check({6'h00, poweredDown, standby}, {6'h00, down, !down});
    endtask : settle

    task automatic frame2(input logic [8:0] bits, input int n);
        link2.csN = 1'b0;
        for (int i = n - 1; i >= 0; i--)
        begin
            link2.mosi = bits[i];
            repeat (4) @(negedge clk);
            link2.sclk = 1'b1;
            repeat (4) @(negedge clk);
            link2.sclk = 1'b0;
        end
        repeat (4) @(negedge clk);
        link2.csN = 1'b1;
        link2.mosi = ~link2.mosi;
        repeat (40) @(negedge clk);
    endtask : frame2

    initial
    begin
        link2.csN = 1'b1;
        link2.sclk = 1'b0;
        link2.mosi = 1'b0;
        repeat (30000) @(posedge clk);
        errorCnt++;
        $display("watchdog expired");
        wrap_up();
    end

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial
    begin
        void'($urandom(32'hde0a));
        repeat (16) @(negedge clk);
        rst = 1'b0;
        repeat (26) @(negedge clk);
        check(8'(standby), 8'h01);
        check(8'(cmdReady), 8'h01);
        check(8'(writeAllowed), 8'h00);
        cmdWrite = 1'b1;
        cmdStart = 1'b1;
        @(negedge clk);
        cmdStart = 1'b0;
        cmdWrite = 1'b0;
        repeat (8) @(negedge clk);
        check(8'(link.csN), 8'h01);
        $display("test done: power-up waits");
        for (int i = 0; i < 5; i++)
        begin
            code = plain(8'($urandom));
            v0 = validCnt;
            send(code, 1'b1, i == 4);
            check(rxData, expRx(1'b0, respData));
            check(devCode, code);
            check(8'(validCnt - v0), 8'h01);
        end
        $display("test done: normal commands");
        for (int m = 0; m < 3; m++)
        begin
            send(8'hb9, 1'b0, 1'b0);
            settle(1'b1);
            check(8'(linkAsleep), 8'h01);
            v0 = validCnt;
            for (int i = 0; i < 3; i++)
            begin
                send(i == 0 ? 8'h05 : plain(8'($urandom)), 1'b1, 1'b0);
                check(rxData, expRx(1'b1, respData));
            end
            check(8'(validCnt - v0), 8'h00);
            v0 = resetCnt;
            if (m == 2)
            begin
                send(8'h66, 1'b0, 1'b0);
                send(8'h05, 1'b0, 1'b0);
                send(8'h99, 1'b0, 1'b0);
                check(8'(poweredDown), 8'h01);
                send(8'h66, 1'b0, 1'b0);
            end
            send(m == 0 ? 8'hab : (m == 1 ? 8'hff : 8'h99), 1'b0, 1'b0);
            settle(1'b0);
            check(8'(linkAsleep), 8'h00);
            check(8'(resetCnt - v0), 8'(m != 0));
        end
        $display("test done: power-down and wake");
        frame2({8'hb9, 1'b0}, 9);
        check(8'(down2), 8'h00);
        frame2(9'h05c, 7);
        check(8'(down2), 8'h00);
        frame2(9'h0b9, 8);
        check(8'(down2), 8'h01);
        $display("test done: framing");
        wrap_up();
    end
endmodule : spi_deep_power_down_control_bench
